// [hdl/rjaic_core.v]
// End-aligned stereo audio receiver with coefficient holder and register map
`default_nettype none
`include "rjaic_regs.vh"

module rjaic_core #(
   parameter [7:0] IDENT_CODE = `RJAIC_IDENT_DEFAULT
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // Serial audio pins, asynchronous to clk_i
   input wire bit_clock_i,
   input wire frame_channel_clock_i,
   input wire serial_audio_in_i,
   // Register access port
   input wire [7:0] reg_addr_i,
   input wire reg_wr_i,
   input wire [15:0] reg_wdata_i,
   output wire [15:0] reg_rdata_o,
   // Gain coefficient load port
   input wire coef_wr_i,
   input wire [31:0] coef_wdata_i,
   output wire [25:0] coef_o,
   output wire coef_neg_o,
   output wire [2:0] coef_int_o,
   // Received audio
   output wire [23:0] left_sample_o,
   output wire [23:0] right_sample_o,
   output wire sample_valid_o,
   output wire sample_left_o,
   output wire [5:0] slot_bits_o
);

   // Pin synchronisers, stage one read only by stage two
   reg bclk_s1_q;
   reg bclk_s2_q;
   reg bclk_s3_q;
   reg frame_channel_clock_s1_q;
   reg frame_channel_clock_s2_q;
   reg serial_audio_in_s1_q;
   reg serial_audio_in_s2_q;

   // Receiver state
   reg [23:0] shift_q; // Last 24 bits seen, not cleared between slots
   reg [5:0] cnt_q; // Bits counted in current slot
   reg frame_channel_clock_prev_q; // Frame clock at previous bit edge
   reg seen_edge_q; // First transition already seen
   reg [23:0] left_q;
   reg [23:0] right_q;
   reg valid_q;
   reg chan_left_q;
   reg [5:0] slot_bits_q;

   // Register file
   reg [15:0] regs_q [0:`RJAIC_NUM_REGS-1];
   reg [7:0] err_q; // Sticky error flags
   reg [15:0] rdata_q;
   reg [25:0] coef_q;

   // Decoded bit clock rising edge
   wire bclk_rise;
   wire frame_channel_clock_flip;
   wire [1:0] wl_sel;
   reg [23:0] word_ext; // Word trimmed and sign extended
   reg [5:0] wl_bits; // Selected word length in bits
   reg ratio_ok;

   // Reset value per subaddress
   function [15:0] rst_val;
      input integer idx;
      begin
         case (idx)
            0: rst_val = `RJAIC_RST_CLOCK_CONTROL;
            3: rst_val = `RJAIC_RST_SYSTEM_CONTROL_ONE;
            4: rst_val = `RJAIC_RST_AUDIO_PORT_FORMAT;
            5: rst_val = `RJAIC_RST_SYSTEM_CONTROL_TWO;
            6: rst_val = `RJAIC_RST_GENTLE_SILENCE;
            7: rst_val = `RJAIC_RST_OVERALL_LOUDNESS;
            8: rst_val = `RJAIC_RST_LOUDNESS_CHAN;
            9: rst_val = `RJAIC_RST_LOUDNESS_CHAN;
            10: rst_val = `RJAIC_RST_LOUDNESS_CHAN;
            14: rst_val = `RJAIC_RST_LOUDNESS_SETUP;
            16: rst_val = `RJAIC_RST_MODULATION_CEILING;
            17: rst_val = `RJAIC_RST_SKEW_ODD;
            18: rst_val = `RJAIC_RST_SKEW_EVEN;
            19: rst_val = `RJAIC_RST_SKEW_ODD;
            20: rst_val = `RJAIC_RST_SKEW_EVEN;
            24: rst_val = `RJAIC_RST_MODULATOR_LAUNCH;
            25: rst_val = `RJAIC_RST_MODULATOR_HALT_GROUP;
            26: rst_val = `RJAIC_RST_LAUNCH_HALT_PERIOD;
            27: rst_val = `RJAIC_RST_OSCILLATOR_ADJUST;
            default: rst_val = `RJAIC_RST_ZERO;
         endcase
      end
   endfunction

   // Host-writable entries; reserved, identity and status excluded
   function is_rw;
      input integer idx;
      begin
         case (idx)
            1, 2, 11, 12, 13, 15, 21, 22, 23: is_rw = 1'b0;
            default: is_rw = 1'b1;
         endcase
      end
   endfunction

   // Two-byte entries keep sixteen bits, the rest eight
   function [15:0] width_mask;
      input integer idx;
      begin
         if (idx >= 7 && idx <= 12) begin
            width_mask = `RJAIC_MASK_WIDE;
         end else begin
            width_mask = `RJAIC_MASK_NARROW;
         end
      end
   endfunction

   // Two flip-flops on every pin before any logic looks at it
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bclk_s1_q <= 1'b0;
         bclk_s2_q <= 1'b0;
         bclk_s3_q <= 1'b0;
         frame_channel_clock_s1_q <= 1'b0;
         frame_channel_clock_s2_q <= 1'b0;
         serial_audio_in_s1_q <= 1'b0;
         serial_audio_in_s2_q <= 1'b0;
      end else begin
         bclk_s1_q <= bit_clock_i;
         bclk_s2_q <= bclk_s1_q;
         bclk_s3_q <= bclk_s2_q;
         frame_channel_clock_s1_q <= frame_channel_clock_i;
         frame_channel_clock_s2_q <= frame_channel_clock_s1_q;
         serial_audio_in_s1_q <= serial_audio_in_i;
         serial_audio_in_s2_q <= serial_audio_in_s1_q;
      end
   end

   assign bclk_rise = bclk_s2_q & ~bclk_s3_q;
   // Frame clock seen changed at this bit edge
   assign frame_channel_clock_flip = bclk_rise & (frame_channel_clock_s2_q != frame_channel_clock_prev_q);
   assign wl_sel = regs_q[4][`RJAIC_WL_MSB:`RJAIC_WL_LSB];

   // Trim the slot to the chosen word and sign extend it
   always @* begin
      word_ext = 24'h000000;
      wl_bits = `RJAIC_BITS_24;
      case (wl_sel)
         `RJAIC_WL_16: begin
            wl_bits = `RJAIC_BITS_16;
            word_ext = {{8{shift_q[15]}}, shift_q[15:0]};
         end
         `RJAIC_WL_20: begin
            wl_bits = `RJAIC_BITS_20;
            word_ext = {{4{shift_q[19]}}, shift_q[19:0]};
         end
         default: begin
            wl_bits = `RJAIC_BITS_24;
            word_ext = shift_q;
         end
      endcase
   end

   // Slot lengths that the receiver recognises
   always @* begin
      case (cnt_q)
         `RJAIC_SLOT_32: ratio_ok = 1'b1;
         `RJAIC_SLOT_48: ratio_ok = 1'b1;
         `RJAIC_SLOT_64: ratio_ok = 1'b1;
         default: ratio_ok = 1'b0;
      endcase
   end

   // Serial shifter and slot counter
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift_q <= 24'h000000;
         cnt_q <= 6'h00;
         frame_channel_clock_prev_q <= 1'b0;
         seen_edge_q <= 1'b0;
      end else if (bclk_rise) begin
         shift_q <= {shift_q[22:0], serial_audio_in_s2_q};
         frame_channel_clock_prev_q <= frame_channel_clock_s2_q;
         if (frame_channel_clock_flip) begin
            // new slot, this bit is first
            cnt_q <= 6'h01;
            seen_edge_q <= 1'b1;
         end else if (cnt_q != `RJAIC_CNT_MAX) begin
            // Saturate so a stuck frame clock cannot wrap
            cnt_q <= cnt_q + 6'h01;
         end
      end
   end

   // Word capture at each frame clock transition
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         left_q <= 24'h000000;
         right_q <= 24'h000000;
         valid_q <= 1'b0;
         chan_left_q <= 1'b0;
         slot_bits_q <= 6'h00;
      end else begin
         valid_q <= 1'b0;
         // First partial slot after reset is discarded
         if (frame_channel_clock_flip && seen_edge_q) begin
            // word ends on last slot bit
            valid_q <= 1'b1;
            slot_bits_q <= cnt_q;
            chan_left_q <= frame_channel_clock_prev_q;
            if (frame_channel_clock_prev_q) begin
               left_q <= word_ext;
            end else begin
               right_q <= word_ext;
            end
         end
      end
   end

   // Per-entry control registers, one generate loop
   genvar gi;
   generate
      for (gi = 0; gi < `RJAIC_NUM_REGS; gi = gi + 1) begin : g_reg
         always @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               regs_q[gi] <= rst_val(gi);
            end else if (reg_wr_i && reg_addr_i == gi && is_rw(gi)) begin
               // Unused upper bits are never stored
               regs_q[gi] <= reg_wdata_i & width_mask(gi);
            end
         end
      end
   endgenerate

   // Sticky error flags; a new event beats a host clear
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         err_q <= `RJAIC_RST_ERROR_STATUS;
      end else begin
         if (reg_wr_i && reg_addr_i == `RJAIC_OFS_ERROR_STATUS) begin
            err_q <= reg_wdata_i[7:0];
         end
         if (frame_channel_clock_flip && seen_edge_q) begin
            // Slot too short for the word
            if (cnt_q < wl_bits) begin
               err_q[`RJAIC_ERR_SHORT_SLOT] <= 1'b1;
            end
            // Slot length outside the three ratios
            if (!ratio_ok) begin
               err_q[`RJAIC_ERR_BAD_RATIO] <= 1'b1;
            end
         end
      end
   end

   // Coefficient holder
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         coef_q <= 26'h0000000;
      end else if (coef_wr_i) begin
         // low 26 bits kept, top six ignored
         coef_q <= coef_wdata_i[`RJAIC_COEF_MSB:0];
      end
   end

   // Registered read data, reserved reads as zero
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= 16'h0000;
      end else begin
         case (reg_addr_i)
            `RJAIC_OFS_DEVICE_IDENTITY: rdata_q <= {8'h00, IDENT_CODE};
            `RJAIC_OFS_ERROR_STATUS: rdata_q <= {8'h00, err_q};
            // Reserved entries return zero so nothing leaks out
            `RJAIC_OFS_RESERVED_0B,
            `RJAIC_OFS_RESERVED_0C,
            `RJAIC_OFS_RESERVED_0D,
            `RJAIC_OFS_RESERVED_0F,
            `RJAIC_OFS_RESERVED_15,
            `RJAIC_OFS_RESERVED_16,
            `RJAIC_OFS_RESERVED_17: rdata_q <= 16'h0000;
            default: begin
               if (reg_addr_i <= `RJAIC_LAST_OFS) begin
                  rdata_q <= regs_q[reg_addr_i[4:0]];
               end else begin
                  // Beyond this map reads as zero
                  rdata_q <= 16'h0000;
               end
            end
         endcase
      end
   end

   // Outputs
   assign reg_rdata_o = rdata_q;
   assign coef_o = coef_q;
   assign coef_neg_o = coef_q[`RJAIC_COEF_MSB];
   assign coef_int_o = coef_q[`RJAIC_COEF_MSB:`RJAIC_COEF_INT_LSB];
   assign left_sample_o = left_q;
   assign right_sample_o = right_q;
   assign sample_valid_o = valid_q;
   assign sample_left_o = chan_left_q;
   assign slot_bits_o = slot_bits_q;

endmodule
`default_nettype wire

// [hdl/rjaic_regs.vh]
// Constants for the end-aligned audio receiver and its control map
`ifndef RJAIC_REGS_VH
`define RJAIC_REGS_VH

// Register subaddresses
`define RJAIC_OFS_CLOCK_CONTROL 8'h00
`define RJAIC_OFS_DEVICE_IDENTITY 8'h01
`define RJAIC_OFS_ERROR_STATUS 8'h02
`define RJAIC_OFS_SYSTEM_CONTROL_ONE 8'h03
`define RJAIC_OFS_AUDIO_PORT_FORMAT 8'h04
`define RJAIC_OFS_SYSTEM_CONTROL_TWO 8'h05
`define RJAIC_OFS_GENTLE_SILENCE 8'h06
`define RJAIC_OFS_OVERALL_LOUDNESS 8'h07
`define RJAIC_OFS_LOUDNESS_CHAN_ONE 8'h08
`define RJAIC_OFS_LOUDNESS_CHAN_TWO 8'h09
`define RJAIC_OFS_LOUDNESS_CHAN_THREE 8'h0A
`define RJAIC_OFS_RESERVED_0B 8'h0B
`define RJAIC_OFS_RESERVED_0C 8'h0C
`define RJAIC_OFS_RESERVED_0D 8'h0D
`define RJAIC_OFS_LOUDNESS_SETUP 8'h0E
`define RJAIC_OFS_RESERVED_0F 8'h0F
`define RJAIC_OFS_MODULATION_CEILING 8'h10
`define RJAIC_OFS_OUTPUT_SKEW_ONE 8'h11
`define RJAIC_OFS_OUTPUT_SKEW_TWO 8'h12
`define RJAIC_OFS_OUTPUT_SKEW_THREE 8'h13
`define RJAIC_OFS_OUTPUT_SKEW_FOUR 8'h14
`define RJAIC_OFS_RESERVED_15 8'h15
`define RJAIC_OFS_RESERVED_16 8'h16
`define RJAIC_OFS_RESERVED_17 8'h17
`define RJAIC_OFS_MODULATOR_LAUNCH 8'h18
`define RJAIC_OFS_MODULATOR_HALT_GROUP 8'h19
`define RJAIC_OFS_LAUNCH_HALT_PERIOD 8'h1A
`define RJAIC_OFS_OSCILLATOR_ADJUST 8'h1B
`define RJAIC_NUM_REGS 28
`define RJAIC_LAST_OFS 8'h1B

// Reset values
`define RJAIC_RST_CLOCK_CONTROL 16'h006C
`define RJAIC_RST_ERROR_STATUS 8'h00
`define RJAIC_RST_SYSTEM_CONTROL_ONE 16'h00A0
`define RJAIC_RST_AUDIO_PORT_FORMAT 16'h0005
`define RJAIC_RST_SYSTEM_CONTROL_TWO 16'h0040
`define RJAIC_RST_GENTLE_SILENCE 16'h0000
`define RJAIC_RST_OVERALL_LOUDNESS 16'h03FF
`define RJAIC_RST_LOUDNESS_CHAN 16'h00C0
`define RJAIC_RST_LOUDNESS_SETUP 16'h00F0
`define RJAIC_RST_MODULATION_CEILING 16'h0001
`define RJAIC_RST_SKEW_ODD 16'h00AC
`define RJAIC_RST_SKEW_EVEN 16'h0054
`define RJAIC_RST_MODULATOR_LAUNCH 16'h000F
`define RJAIC_RST_MODULATOR_HALT_GROUP 16'h0030
`define RJAIC_RST_LAUNCH_HALT_PERIOD 16'h0068
`define RJAIC_RST_OSCILLATOR_ADJUST 16'h0082
`define RJAIC_RST_ZERO 16'h0000

// Data widths of narrow and wide registers
`define RJAIC_MASK_NARROW 16'h00FF
`define RJAIC_MASK_WIDE 16'hFFFF

// Word length field in audio_port_format
`define RJAIC_WL_LSB 0
`define RJAIC_WL_MSB 1
`define RJAIC_WL_16 2'h0
`define RJAIC_WL_20 2'h1
`define RJAIC_WL_24 2'h2
`define RJAIC_BITS_16 6'h10
`define RJAIC_BITS_20 6'h14
`define RJAIC_BITS_24 6'h18

// Error status bits
`define RJAIC_ERR_SHORT_SLOT 0
`define RJAIC_ERR_BAD_RATIO 1

// Slot lengths for 32, 48 and 64 bit clocks per frame
`define RJAIC_SLOT_32 6'h10
`define RJAIC_SLOT_48 6'h18
`define RJAIC_SLOT_64 6'h20
`define RJAIC_CNT_MAX 6'h3F

// Coefficient layout, 3.23 signed
`define RJAIC_COEF_MSB 25
`define RJAIC_COEF_FRAC_MSB 22
`define RJAIC_COEF_INT_LSB 23

// Identity code value is arbitrary
`define RJAIC_IDENT_DEFAULT 8'h5A

`endif

// [verif/rjaic_core_monitor.sv]
// Port checker for the end-aligned audio receiver
`default_nettype none
module rjaic_core_monitor (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Serial audio pins
   input wire logic bit_clock_i,
   input wire logic frame_channel_clock_i,
   input wire logic serial_audio_in_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic [15:0] reg_rdata_o,
   // Coefficient port
   input wire logic coef_wr_i,
   input wire logic [31:0] coef_wdata_i,
   input wire logic [25:0] coef_o,
   input wire logic coef_neg_o,
   input wire logic [2:0] coef_int_o,
   // Received audio
   input wire logic [23:0] left_sample_o,
   input wire logic [23:0] right_sample_o,
   input wire logic sample_valid_o,
   input wire logic sample_left_o,
   input wire logic [5:0] slot_bits_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // Shadow of the word length field
   logic [1:0] wl_q;
   // Low coefficient bits that must be kept
   wire [25:0] cw = coef_wdata_i[25:0];
   // Reserved or unmapped subaddress
   wire rsv = reg_addr_i > 8'h1B ||
      reg_addr_i inside {8'h0B, 8'h0C, 8'h0D, 8'h0F, [8'h15:8'h17]};
   // Follow writes so sign checks know the width
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wl_q <= 2'h1;
      end else if (reg_wr_i && reg_addr_i == 8'h04) begin
         wl_q <= reg_wdata_i[1:0];
      end
   end
   // Bits above the word must copy its sign
   function automatic logic ext_ok(input logic [23:0] v,
      input logic [1:0] w);
      if (w == 2'h0) return v[23:16] == {8{v[15]}};
      if (w == 2'h1) return v[23:20] == {4{v[19]}};
      return 1'b1;
   endfunction
   chk_coef_load: assert property (coef_wr_i |=> coef_o == $past(cw))
      else $error("coef_o differs from loaded bits");
   chk_coef_hold: assert property (!coef_wr_i |=> $stable(coef_o))
      else $error("coef_o changed without a load");
   chk_coef_sign: assert property (coef_neg_o == coef_o[25])
      else $error("coef_neg_o disagrees with top bit");
   chk_coef_int: assert property (coef_int_o == coef_o[25:23])
      else $error("coef_int_o disagrees with coef_o");
   chk_valid_gap: assert property (
      sample_valid_o |=> !sample_valid_o [*8])
      else $error("sample_valid_o pulses too close");
   chk_chan_side: assert property (
      sample_valid_o |-> sample_left_o != frame_channel_clock_i)
      else $error("sample_left_o names the wrong channel");
   chk_quiet_hold: assert property (!sample_valid_o |->
      $stable(left_sample_o) && $stable(right_sample_o))
      else $error("sample changed without a capture");
   chk_sign_ext: assert property (sample_valid_o |-> ext_ok(
      sample_left_o ? left_sample_o : right_sample_o, wl_q))
      else $error("sample not sign extended");
   chk_rsv_zero: assert property (
      $stable(reg_addr_i) && rsv |=> reg_rdata_o == 16'h0000)
      else $error("reserved place reads nonzero");
   cov_left: cover property (sample_valid_o && sample_left_o);
   cov_right: cover property (sample_valid_o && !sample_left_o);
   cov_neg_coef: cover property (coef_wr_i ##1 coef_neg_o);
endmodule
bind rjaic_core rjaic_core_monitor u_mon (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .bit_clock_i(bit_clock_i),
   .frame_channel_clock_i(frame_channel_clock_i),
   .serial_audio_in_i(serial_audio_in_i), .reg_addr_i(reg_addr_i),
   .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o), .coef_wr_i(coef_wr_i),
   .coef_wdata_i(coef_wdata_i), .coef_o(coef_o), .coef_neg_o(coef_neg_o),
   .coef_int_o(coef_int_o), .left_sample_o(left_sample_o),
   .right_sample_o(right_sample_o), .sample_valid_o(sample_valid_o),
   .sample_left_o(sample_left_o), .slot_bits_o(slot_bits_o)
);
`default_nettype wire

// [verif/rjaic_source.sv]
// Model of the outside audio source sending end-aligned frames
`default_nettype none
module rjaic_source (
   // Serial audio pins
   output var logic bck_o,
   output var logic fck_o,
   output var logic dat_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle pins; the bit clock moves only while half sends a slot
   initial begin
      bck_o = 1'b0;
      fck_o = 1'b0;
      dat_o = 1'b0;
   end
   task automatic half(input logic lvl, input int slot,
      input logic [31:0] vec);
      fck_o = lvl;
      for (int i = slot - 1; i >= 0; i--) begin
         dat_o = vec[i];
         #160 bck_o = 1'b1;
         #160 bck_o = 1'b0;
      end
      // Released line flips so a held value cannot pass
      dat_o = ~dat_o;
   endtask
endmodule
`default_nettype wire

// [verif/tb_rj_audio_input_and_control_map.sv]
// Self-checking bench for the end-aligned receiver and its map
`default_nettype none
module tb_rj_audio_input_and_control_map;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] IDENT = 8'hA7; // Arbitrary identity value
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic coef_wr_i = 1'b0;
   logic [31:0] coef_wdata_i = 32'h00000000;
   wire bck, fck, dat, cneg, svalid, sleft;
   wire [15:0] rdata;
   wire [25:0] coef;
   wire [2:0] cint;
   wire [23:0] lsmp, rsmp;
   wire [5:0] sbits;
   int bad_count = 0;
   int n_compared = 0;
   logic [31:0] prev_r = 32'h00000000; // Nothing captured yet
   rjaic_core #(.IDENT_CODE(IDENT)) dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .bit_clock_i(bck),
      .frame_channel_clock_i(fck), .serial_audio_in_i(dat),
      .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata),
      .coef_wr_i(coef_wr_i), .coef_wdata_i(coef_wdata_i), .coef_o(coef),
      .coef_neg_o(cneg), .coef_int_o(cint), .left_sample_o(lsmp),
      .right_sample_o(rsmp), .sample_valid_o(svalid),
      .sample_left_o(sleft), .slot_bits_o(sbits));
   rjaic_source src (.bck_o(bck), .fck_o(fck), .dat_o(dat));
   always #20 clk_i = ~clk_i;
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict();
      if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge clk_i);
      reg_wr_i = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(negedge clk_i);
      reg_addr_i = a;
      repeat (2) @(negedge clk_i);
      chk("reg_rdata_o", {16'h0000, rdata}, {16'h0000, e}); // Map
   endtask
   // Reset value of each place; hidden ones read zero
   function automatic logic [15:0] rst_val(input logic [7:0] a);
      logic [15:0] t [0:28];
      t = '{16'h6C, {8'h00, IDENT}, 16'h0, 16'hA0, 16'h5, 16'h40, 16'h0,
         16'h3FF, 16'hC0, 16'hC0, 16'hC0, 16'h0, 16'h0, 16'h0, 16'hF0,
         16'h0, 16'h1, 16'hAC, 16'h54, 16'hAC, 16'h54, 16'h0, 16'h0,
         16'h0, 16'hF, 16'h30, 16'h68, 16'h82, 16'h0};
      return t[a];
   endfunction
   // Read-back after a write; refused places keep their value
   function automatic logic [15:0] wr_val(input logic [7:0] a,
      input logic [15:0] d);
      if (a == 8'h01 || a > 8'h1B ||
         a inside {8'h0B, 8'h0C, 8'h0D, 8'h0F, [8'h15:8'h17]}) begin
         return rst_val(a);
      end
      return (a inside {[8'h07:8'h0A]}) ? d : {8'h00, d[7:0]};
   endfunction
   // Last n bits of a slot, sign extended to 24
   function automatic logic [31:0] sx(input logic [31:0] v, input int n);
      logic [31:0] m;
      m = 32'hFFFFFFFF << n;
      return (v[n-1] ? (v | m) : (v & ~m)) & 32'h00FFFFFF;
   endfunction
   // One stereo frame; the right word shows at the next frame
   task automatic pair(input int slot, input logic [1:0] w);
      logic [31:0] lv, rv;
      int n;
      lv = $urandom;
      rv = $urandom;
      n = (w == 2'h0) ? 16 : (w == 2'h1) ? 20 : 24;
      src.half(1'b1, slot, lv);
      chk("right_sample_o", rsmp, sx(prev_r, n)); // Pad dropped
      chk("sample_left_o", sleft, 32'h0); // Right slot low
      src.half(1'b0, slot, rv);
      chk("left_sample_o", lsmp, sx(lv, n)); // Word at end
      chk("sample_left_o", sleft, 32'h1); // Left slot high
      chk("slot_bits_o", sbits, slot); // Counted bits
      prev_r = rv;
   endtask
   initial begin
      #2000000;
      bad_count++;
      give_verdict();
   end
   initial begin
      logic [15:0] d;
      logic [31:0] c;
      logic [31:0] cc [0:3];
      int sl [0:7];
      logic [1:0] wc [0:7];
      cc = '{32'h00800000, 32'hFFFFFFFF, 32'hFC000000, 32'h02000000};
      sl = '{32, 32, 32, 24, 24, 24, 16, 16};
      wc = '{2'h2, 2'h1, 2'h0, 2'h3, 2'h1, 2'h0, 2'h0, 2'h0};
      void'($urandom(32'hCF39F6F5));
      repeat (5) @(negedge clk_i);
      rst_n_i = 1'b1;
      for (int a = 0; a < 29; a++) begin
         rd(a[7:0], rst_val(a[7:0]));
      end
      for (int a = 0; a < 29; a++) begin
         if (a == 2) continue;
         d = $urandom;
         wr(a[7:0], d);
         rd(a[7:0], wr_val(a[7:0], d));
      end
      // Back-to-back loads, corners first
      for (int i = 0; i < 12; i++) begin
         c = (i < 4) ? cc[i] : $urandom;
         coef_wdata_i = c;
         coef_wr_i = 1'b1;
         @(negedge clk_i);
         chk("coef_o", coef, c[25:0]); // Low bits kept
         chk("coef_neg_o", cneg, c[25]); // Sign bit
         chk("coef_int_o", cint, c[25:23]); // Integer part
      end
      coef_wr_i = 1'b0;
      // Every ratio and word length
      for (int i = 0; i < 8; i++) begin
         wr(8'h04, {14'h0000, wc[i]});
         pair(sl[i], wc[i]); // Ratios and widths
      end
      // Clean slots leave the error flags clear
      rd(8'h02, 16'h0000); // No short slot yet
      // A 16-bit slot cannot hold a 24-bit word
      wr(8'h04, 16'h0002);
      src.half(1'b1, 16, 32'h00000000);
      src.half(1'b0, 16, 32'h00000000);
      rd(8'h02, 16'h0001); // Short slot flagged
      // Host clear with the link idle
      wr(8'h02, 16'h0000);
      rd(8'h02, 16'h0000); // Flags cleared
      give_verdict();
   end
endmodule
`default_nettype wire
